// ---- include/ipa_pkg.sv ----
// Shared constants, types and rank helpers for the IRQ priority arbiter.
// Assumes a 32-bit APB master and byte addresses on paddr.
package ipa_pkg;
	localparam logic [31:0] ADDR_MCFG  = 32'h01e00014;
	localparam logic [31:0] ADDR_SCUR  = 32'h01e00018;
	localparam logic [31:0] ADDR_MCUR  = 32'h01e0001c;
	localparam logic [31:0] ADDR_SVC   = 32'h01e00020;
	localparam logic [31:0] ADDR_EVST  = 32'h01e00030;
	localparam logic [31:0] ADDR_EVMSK = 32'h01e00034;
	localparam logic [31:0] MCFG_RST   = 32'h00001f1b;
	localparam logic [31:0] SCUR_RST   = 32'h1b1b1b1b;
	localparam logic [7:0]  RANK_RST   = 8'h1b;
	localparam logic [15:0] MCFG_WMASK = 16'h1fff;
	localparam int          MMODE_BIT  = 12;
	localparam int          GMODE_HI   = 11;
	localparam int          NUM_SRC    = 26;
	localparam int          SRC_RTC    = 1;
	localparam int          SRC_ADC    = 0;
	localparam int          EV_W       = 3;
	localparam int          EV_REQ     = 0;
	localparam int          EV_GRANT   = 1;
	localparam int          EV_CLASH   = 2;
	// Base of the branch code; the value is arbitrary
	localparam logic [5:0]  VEC_BASE   = 6'h08;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'b01,
		SVC_BUSY = 2'b10
	} ipa_svc_t;

	// Rank code of one slot, slot 0 in the top two bits
	function automatic logic [1:0] rank_of(input logic [7:0] ranks, input int slot);
		rank_of = ranks[(3 - slot) * 2 +: 2];
	endfunction : rank_of

	// Best requesting slot: {valid, slot}, lowest rank code wins
	function automatic logic [2:0] best_slot(input logic [3:0] req, input logic [7:0] ranks);
		logic [2:0] res;
		int         i;
		res = 3'h0;
		for (i = 0; i < 4; i++)
		begin
			if (req[i] && (!res[2] || rank_of(ranks, i) < rank_of(ranks, int'(res[1:0]))))
				res = {1'b1, 2'(i)};
		end
		best_slot = res;
	endfunction : best_slot

	// Winner drops to last rank, those behind it move up one
	function automatic logic [7:0] rank_rotate(input logic [7:0] ranks, input logic [1:0] slot);
		logic [7:0] res;
		logic [1:0] w;
		int         i;
		res = ranks;
		w = rank_of(ranks, int'(slot));
		for (i = 0; i < 4; i++)
		begin
			if (i == int'(slot))
				res[(3 - i) * 2 +: 2] = 2'h3;
			else if (rank_of(ranks, i) > w)
				res[(3 - i) * 2 +: 2] = rank_of(ranks, i) - 2'h1;
		end
		rank_rotate = res;
	endfunction : rank_rotate

	// True when all four rank codes differ
	function automatic logic ranks_distinct(input logic [7:0] r);
		ranks_distinct = (r[7:6] != r[5:4]) && (r[7:6] != r[3:2]) && (r[7:6] != r[1:0])
			&& (r[5:4] != r[3:2]) && (r[5:4] != r[1:0]) && (r[3:2] != r[1:0]);
	endfunction : ranks_distinct
endpackage : ipa_pkg

// ---- src/ipa_branch_code_low_code.sv ----
// Low six bits of the branch code for the source being vectored.
// Assumes a source index 0..25 from the arbiter.
`timescale 1ns/1ns
`default_nettype none
module ipa_branch_code_low_code
	import ipa_pkg::*;
(
	input  wire logic [4:0] src_idx,
	output logic [5:0]      code_low
);
	// Table is ordered from the highest source index down
	always_comb
	begin
		code_low = 6'(VEC_BASE + 6'(5'd25 - src_idx));
	end
endmodule : ipa_branch_code_low_code
`default_nettype wire

// ---- src/ipa_rank_arb.sv ----
// Four-slot rank arbiter with fixed or round-robin live order.
// Assumes distinct programmed rank codes and a one-cycle grant pulse.
`timescale 1ns/1ns
`default_nettype none
module ipa_rank_arb
	import ipa_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [3:0] req,
	input  wire logic [7:0] prog_rank,
	input  wire logic       fixed_mode,
	input  wire logic       reload,
	input  wire logic       grant,
	output logic [7:0]      live_rank,
	output logic            win_valid,
	output logic [1:0]      win_slot
);
	logic [7:0] next_live_rank;
	logic [2:0] best;

	// Winner by live order, so round-robin changes take effect at once
	assign best      = best_slot(req, live_rank);
	assign win_valid = best[2];
	assign win_slot  = best[1:0];

	// Fixed mode mirrors the program; round-robin rotates on grant
	always_comb
	begin
		next_live_rank = live_rank;
		if (fixed_mode || reload)
			next_live_rank = prog_rank;
		else if (grant && win_valid)
			next_live_rank = rank_rotate(live_rank, win_slot);
	end

	// Live order register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			live_rank <= RANK_RST;
		else
			live_rank <= next_live_rank;
	end

	fixed_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		fixed_mode |=> live_rank == $past(prog_rank))
		else $error("live order does not follow program in fixed mode");

	rr_rotate_a: assert property (@(posedge core_clk) disable iff (rst)
		(!fixed_mode && !reload && grant && win_valid)
		|=> rank_of(live_rank, int'($past(win_slot))) == 2'h3)
		else $error("granted slot not moved to last rank");
endmodule : ipa_rank_arb
`default_nettype wire

// ---- src/ipa_top.sv ----
// IRQ priority arbiter: master config, live rank status, branch code.
// Assumes pending, already masked requests on irq_src and an APB master.
`timescale 1ns/1ns
`default_nettype none
module ipa_top
	import ipa_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [25:0] irq_src,
	input  wire logic [31:0] irq_slave_priority_config,
	input  wire logic        irq_ack,
	input  wire logic        irq_done,
	output logic             core_irq,
	output logic [25:0]      service_pending,
	output logic             event_irq
);
	logic [15:0]     mcfg;
	logic [15:0]     next_mcfg;
	logic [EV_W-1:0] ev_stat;
	logic [EV_W-1:0] next_ev_stat;
	logic [EV_W-1:0] ev_mask;
	logic [EV_W-1:0] next_ev_mask;
	logic [31:0]     next_prdata;
	logic            next_pslverr;
	logic [25:0]     next_service_pending;
	logic [5:0]      branch_code_low;
	logic [5:0]      next_branch_code_low;
	logic [31:0]     slave_cfg_q;
	logic            any_req;
	logic            any_req_q;
	ipa_svc_t        state;
	ipa_svc_t        next_state;
	logic            setup;
	logic            wr;
	logic            mcfg_wr;
	logic            mcfg_wr_q;
	logic            grant;
	logic [7:0]      slave_live [4];
	logic [3:0]      slave_win_valid;
	logic [1:0]      slave_win_slot [4];
	logic [4:0]      grp_idx [4];
	logic [3:0]      grp_req;
	logic [3:0]      prog_any;
	logic [7:0]      live_group_rank;
	logic            m_win_valid;
	logic [1:0]      m_win_slot;
	logic [4:0]      win_idx;
	logic [5:0]      vec_code;
	logic [31:0]     slave_live_word;
	logic [31:0]     mcur_word;

	// Zero-wait slave; read data is prepared in the setup cycle
	assign pready  = 1'b1;
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite;
	assign mcfg_wr = wr && (paddr == ADDR_MCFG);

	// Level request to the core while any source is pending
	assign any_req  = |irq_src;
	assign core_irq = any_req;
	assign event_irq = |(ev_stat & ev_mask);

	assign slave_live_word = {slave_live[0], slave_live[1], slave_live[2], slave_live[3]};
	assign mcur_word = {16'h0000, 2'b00, branch_code_low, live_group_rank};

	// One slave unit per group; source slots are hard wired
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : grp
			localparam int BASE = 25 - 6 * g;
			logic [3:0] sreq;
			logic       k0;
			logic       k1;
			assign sreq = {irq_src[BASE-3], irq_src[BASE-2], irq_src[BASE-1], irq_src[BASE]};
			assign k0   = irq_src[BASE-4];
			assign k1   = irq_src[BASE-5];
			assign prog_any[g] = |sreq;
			assign grp_req[g]  = (|sreq) || k0 || k1;
			assign grp_idx[g] = slave_win_valid[g] ? 5'(BASE - int'(slave_win_slot[g]))
				: (k0 ? 5'(BASE - 4) : 5'(BASE - 5));

			ipa_rank_arb u_slave (
				.core_clk   (core_clk),
				.rst        (rst),
				.req        (sreq),
				.prog_rank  (irq_slave_priority_config[31-8*g -: 8]),
				.fixed_mode (mcfg[GMODE_HI-g]),
				.reload     (irq_slave_priority_config[31-8*g -: 8] != slave_cfg_q[31-8*g -: 8]),
				.grant      (grant && m_win_valid && (m_win_slot == 2'(g))),
				.live_rank  (slave_live[g]),
				.win_valid  (slave_win_valid[g]),
				.win_slot   (slave_win_slot[g])
			);

			fixed_below_a: assert property (@(posedge core_clk) disable iff (rst)
				(grant && m_win_valid && m_win_slot == 2'(g) && prog_any[g])
				|=> !service_pending[BASE-4] && !service_pending[BASE-5])
				else $error("fixed source chosen over programmable one");
		end
	endgenerate

	// master mode bit steers
	// Reload one cycle after the write: at the write edge mcfg still holds the old ranks
	ipa_rank_arb u_master (
		.core_clk   (core_clk),
		.rst        (rst),
		.req        (grp_req),
		.prog_rank  (mcfg[7:0]),
		.fixed_mode (mcfg[MMODE_BIT]),
		.reload     (mcfg_wr_q),
		.grant      (grant),
		.live_rank  (live_group_rank),
		.win_valid  (m_win_valid),
		.win_slot   (m_win_slot)
	);

	always_comb
	begin
		if (m_win_valid)
			win_idx = grp_idx[m_win_slot];
		else if (irq_src[SRC_RTC])
			win_idx = 5'(SRC_RTC);
		else
			win_idx = 5'(SRC_ADC);
	end

	ipa_branch_code_low_code u_vec (
		.src_idx  (win_idx),
		.code_low (vec_code)
	);

	// One service at a time; an acknowledge while busy is ignored
	assign grant = irq_ack && any_req && (state == SVC_IDLE);

	// Service sequence and flags
	always_comb
	begin
		next_state           = state;
		next_service_pending = service_pending;
		next_branch_code_low = branch_code_low;
		case (state)
			SVC_IDLE:
			begin
				if (grant)
				begin
					next_service_pending = 26'h0 | (26'h1 << win_idx);
					next_branch_code_low = vec_code;
					next_state           = SVC_BUSY;
				end
			end
			SVC_BUSY:
			begin
				if (irq_done)
				begin
					next_service_pending = 26'h0;
					next_state           = SVC_IDLE;
				end
			end
			default:
			begin
				next_service_pending = 26'h0;
				next_state           = SVC_IDLE;
			end
		endcase
	end

	// Register file: config, event status and mask, read data
	always_comb
	begin
		next_mcfg    = mcfg;
		next_ev_mask = ev_mask;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (mcfg_wr)
			next_mcfg = pwdata[15:0] & MCFG_WMASK;
		if (wr && (paddr == ADDR_EVMSK))
			next_ev_mask = pwdata[EV_W-1:0];
		// Set wins over write-one-to-clear in the same cycle
		next_ev_stat = ev_stat;
		if (wr && (paddr == ADDR_EVST))
			next_ev_stat = ev_stat & ~pwdata[EV_W-1:0];
		if (any_req && !any_req_q)
			next_ev_stat[EV_REQ] = 1'b1;
		if (grant)
			next_ev_stat[EV_GRANT] = 1'b1;
		if (mcfg_wr && !ranks_distinct(pwdata[7:0]))
			next_ev_stat[EV_CLASH] = 1'b1;
		if (setup)
		begin
			next_pslverr = 1'b0;
			case (paddr)
				ADDR_MCFG:  next_prdata = {16'h0000, mcfg};
				ADDR_SCUR:  next_prdata = slave_live_word;
				ADDR_MCUR:  next_prdata = mcur_word;
				ADDR_SVC:   next_prdata = {6'h00, service_pending};
				ADDR_EVST:  next_prdata = {29'h0, ev_stat};
				ADDR_EVMSK: next_prdata = {29'h0, ev_mask};
				default:
				begin
					next_prdata  = 32'h0;
					next_pslverr = 1'b1;
				end
			endcase
			// Live status and service registers refuse writes
			if (pwrite && (paddr == ADDR_SCUR || paddr == ADDR_MCUR || paddr == ADDR_SVC))
				next_pslverr = 1'b1;
		end
	end

	// All state registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mcfg            <= MCFG_RST[15:0];
			ev_stat         <= '0;
			ev_mask         <= '0;
			prdata          <= 32'h0;
			pslverr         <= 1'b0;
			service_pending <= 26'h0;
			branch_code_low <= 6'h00;
			slave_cfg_q     <= SCUR_RST;
			mcfg_wr_q       <= 1'b0;
			any_req_q       <= 1'b0;
			state           <= SVC_IDLE;
		end
		else
		begin
			mcfg            <= next_mcfg;
			ev_stat         <= next_ev_stat;
			ev_mask         <= next_ev_mask;
			prdata          <= next_prdata;
			pslverr         <= next_pslverr;
			service_pending <= next_service_pending;
			branch_code_low <= next_branch_code_low;
			slave_cfg_q     <= irq_slave_priority_config;
			mcfg_wr_q       <= mcfg_wr;
			any_req_q       <= any_req;
			state           <= next_state;
		end
	end

	mcfg_reset_a: assert property (@(posedge core_clk)
		rst |=> {16'h0000, mcfg} == MCFG_RST)
		else $error("config reset value wrong");

	gmode_reset_a: assert property (@(posedge core_clk)
		rst |=> mcfg[11:8] == 4'hf && mcfg[MMODE_BIT])
		else $error("mode bits not fixed after reset");

	mcfg_write_a: assert property (@(posedge core_clk) disable iff (rst)
		mcfg_wr |=> mcfg[12:0] == $past(pwdata[12:0]) && mcfg[15:13] == 3'b000)
		else $error("config write not stored");

	master_fixed_a: assert property (@(posedge core_clk) disable iff (rst)
		(mcfg[MMODE_BIT] && !mcfg_wr) ##1 grant |=> live_group_rank == $past(mcfg[7:0], 2))
		else $error("master order moved in fixed mode");

	scur_reset_a: assert property (@(posedge core_clk)
		rst |=> slave_live_word == SCUR_RST)
		else $error("slave live status reset wrong");

	mcur_reset_a: assert property (@(posedge core_clk)
		rst |=> live_group_rank == RANK_RST)
		else $error("master live status reset wrong");

	mcur_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(setup && !pwrite && paddr == ADDR_MCUR)
		|=> prdata[15:14] == 2'b00 && prdata[13:8] == $past(branch_code_low))
		else $error("master status read wrong");

	one_svc_a: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(service_pending))
		else $error("more than one service flag");

	code_cap_a: assert property (@(posedge core_clk) disable iff (rst)
		grant |=> branch_code_low == $past(vec_code) && service_pending[$past(win_idx)])
		else $error("branch code or flag not captured");

	direct_last_a: assert property (@(posedge core_clk) disable iff (rst)
		(grant && |irq_src[25:2]) |=> !service_pending[SRC_RTC] && !service_pending[SRC_ADC])
		else $error("direct source won over a group");

	slot_map_a: assert property (@(posedge core_clk) disable iff (rst)
		(grant && irq_src == 26'h2000000) |=> service_pending[25])
		else $error("first external source not in group A slot A");
endmodule : ipa_top
`default_nettype wire

// ---- test/ipa_bench.sv ----
// Self-checking bench: APB register access and vectored service runs.
// Assumes the core model answers acks; slave program changed only at the end.
`timescale 1ns/1ns
`default_nettype none
module irq_priority_arbiter_status_bench
	import ipa_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [25:0] irq_src = 26'h0;
	logic        serve = 1'b0;
	logic [3:0]  hold = 4'h8;
	logic [31:0] slave_prio = 32'h1b1b1b1b;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_irq;
	logic        event_irq;
	logic        irq_ack;
	logic        irq_done;
	logic        busy;
	logic [25:0] service_pending;
	logic [31:0] rd;
	logic        err;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [25:0] tsrc [4] = '{26'h8003, 26'h14000, 26'h3, 26'h1};
	int          tidx [4] = '{15, 16, 1, 0};

	ipa_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_src(irq_src), .irq_slave_priority_config(slave_prio),
		.irq_ack(irq_ack), .irq_done(irq_done), .core_irq(core_irq),
		.service_pending(service_pending), .event_irq(event_irq));

	ipa_core_model i_core (.core_clk(core_clk), .rst(rst), .core_irq(core_irq),
		.serve(serve), .hold(hold), .irq_ack(irq_ack), .irq_done(irq_done), .busy(busy));

	// Free-running clock, 100 ns period
	always #50 core_clk = ~core_clk;

	task automatic conclude();
		$display("Mismatches %0d, checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	// A hung handshake ends the run here rather than spinning forever
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One service run; leaves the master live status in rd
	task automatic take(input logic [25:0] src, input int idx);
		int k;
		irq_src <= src;
		serve <= 1'b1;
		k = 0;
		while (service_pending === 26'h0 && k < 20)
		begin
			@(negedge core_clk);
			k++;
		end
		@(posedge core_clk);
		serve <= 1'b0;
		chk(32'(service_pending), 32'h1 << idx, "serviced source");
		chk(32'(core_irq), 32'h1, "core request");
		apb(1'b0, ADDR_MCUR, 32'h0);
		chk(32'(rd[13:8]), 32'(6'(VEC_BASE + 6'(25 - idx))), "branch code");
		k = 0;
		while (busy !== 1'b0 && k < 40)
		begin
			@(negedge core_clk);
			k++;
		end
		repeat (2) @(negedge core_clk);
		chk(32'(service_pending), 32'h0, "pending cleared");
		// Back on the rising edge so the next stimulus is driven there
		@(posedge core_clk);
	endtask : take

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values of the three registers
		apb(1'b0, ADDR_MCFG, 32'h0);
		chk(rd, 32'h00001f1b, "config reset");
		apb(1'b0, ADDR_SCUR, 32'h0);
		chk(rd, 32'h1b1b1b1b, "slave live reset");
		apb(1'b0, ADDR_MCUR, 32'h0);
		chk(rd & 32'hffffc0ff, 32'h1b, "master live reset");
		chk(32'(core_irq), 32'h0, "no request idle");
		// A refused write and an unmapped place
		apb(1'b1, ADDR_SCUR, 32'hffffffff);
		chk(32'(err), 32'h1, "read-only write");
		apb(1'b0, 32'h01e00028, 32'h0);
		chk({31'h0, err} | rd, 32'h1, "unmapped");
		// Round-robin master, group A fixed, others round-robin
		apb(1'b1, ADDR_EVMSK, 32'h2);
		apb(1'b1, ADDR_MCFG, 32'hffffe8e4);
		apb(1'b0, ADDR_MCFG, 32'h0);
		chk(rd, 32'h000008e4, "config write");
		take(26'h2000080, 7);
		chk(rd & 32'hffffc0ff, 32'h93, "master rotated");
		apb(1'b0, ADDR_SCUR, 32'h0);
		chk(rd, 32'h1b1b1bc6, "slave rotated");
		chk(32'(event_irq), 32'h1, "event raised");
		apb(1'b0, ADDR_EVST, 32'h0);
		chk(rd, 32'h3, "event status");
		apb(1'b1, ADDR_EVST, 32'h2);
		apb(1'b0, ADDR_EVST, 32'h0);
		chk(rd, 32'h1, "event cleared");
		chk(32'(event_irq), 32'h0, "event dropped");
		take(26'h2000000, 25);
		chk(rd & 32'hffffc0ff, 32'hd2, "master rotated again");
		apb(1'b0, ADDR_SCUR, 32'h0);
		chk(rd, 32'h1b1b1bc6, "fixed group kept");
		// Duplicate rank codes are flagged only
		apb(1'b1, ADDR_EVST, 32'h7);
		apb(1'b1, ADDR_MCFG, 32'h00001f00);
		apb(1'b0, ADDR_EVST, 32'h0);
		chk(rd, 32'h4, "duplicate ranks");
		// Fixed mode: low ranked sources, prompt core answers
		apb(1'b1, ADDR_MCFG, 32'h00001f1b);
		hold <= 4'h1;
		for (int i = 0; i < 4; i++)
		begin
			take(tsrc[i], tidx[i]);
			chk(rd & 32'hff, 32'h1b, "fixed order");
		end
		apb(1'b0, ADDR_SCUR, 32'h0);
		chk(rd, 32'h1b1b1b1b, "slave reload");
		// New program for group D is picked up by the live order
		slave_prio <= 32'h1b1b1be4;
		apb(1'b0, ADDR_SCUR, 32'h0);
		chk(rd, 32'h1b1b1be4, "slave program");
		conclude();
	end
endmodule : irq_priority_arbiter_status_bench
`default_nettype wire

// ---- test/ipa_core_model.sv ----
// Behavioural processor core: acknowledges the request, then ends service.
// Assumes one clock shared with the arbiter and a bench-driven serve enable.
`timescale 1ns/1ns
`default_nettype none
module ipa_core_model
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       core_irq,
	input  wire logic       serve,
	input  wire logic [3:0] hold,
	output logic            irq_ack,
	output logic            irq_done,
	output logic            busy
);
	logic [3:0] cnt;

	// One ack per service; a gap after done keeps ack and done apart
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			irq_ack <= 1'b0;
			irq_done <= 1'b0;
			busy <= 1'b0;
			cnt <= 4'h0;
		end
		else
		begin
			irq_ack <= 1'b0;
			irq_done <= 1'b0;
			if (!busy && !irq_done && serve && core_irq)
			begin
				irq_ack <= 1'b1;
				busy <= 1'b1;
				cnt <= hold;
			end
			else if (busy && !irq_ack)
			begin
				if (cnt == 4'h0)
				begin
					irq_done <= 1'b1;
					busy <= 1'b0;
				end
				else
					cnt <= cnt - 4'h1;
			end
		end
	end
endmodule : ipa_core_model
`default_nettype wire
